/* twd_pkg.sv */
`default_nettype none
package twd_pkg;
  // ----------------------------------------------------------------
  // Target addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TWD_ADR_IDENT   = 8'h00;  // Device identity
  localparam logic [7:0] TWD_ADR_REV     = 8'h01;  // Silicon revision
  localparam logic [7:0] TWD_ADR_FPCTRL  = 8'h02;  // Flash programming control
  localparam logic [7:0] TWD_ADR_PLATCH  = 8'h80;  // Port latch
  localparam logic [7:0] TWD_ADR_OUTMODE = 8'hA4;  // Port output mode
  localparam logic [7:0] TWD_ADR_FPDATA  = 8'hB4;  // Flash programming data
  localparam logic [7:0] TWD_ADR_INMODE  = 8'hF1;  // Port input mode
  // ----------------------------------------------------------------
  // Flash command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TWD_CMD_BREAD   = 8'h06;  // Block read
  localparam logic [7:0] TWD_CMD_BWRITE  = 8'h07;  // Block write
  localparam logic [7:0] TWD_CMD_PERASE  = 8'h08;  // Page erase
  localparam logic [7:0] TWD_CMD_DERASE  = 8'h03;  // Whole device erase
  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] TWD_RST_TARGET  = 8'h00;  // Address register
  localparam logic [7:0] TWD_RST_FPCTRL  = 8'h00;  // Control register
  localparam logic [7:0] TWD_RST_LATCH   = 8'hFF;  // Port latch
  localparam logic [7:0] TWD_RST_MODE    = 8'hFF;  // Input mode: digital
  localparam logic [7:0] TWD_RST_OUTMODE = 8'h00;  // Output mode: open drain
  localparam int         TWD_FPC_ENABLE  = 0;      // Program enable bit
  localparam int         TWD_SHARED_BIT  = 7;      // Port bit lent to link
  // ----------------------------------------------------------------
  // Link framing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] TWD_INSTR_BITS  = 4'h2;   // Instruction length
  localparam logic [3:0] TWD_DATA_BITS   = 4'h8;   // Data length
  localparam logic [3:0] TWD_TURN_CYC    = 4'h8;   // Read turnaround clocks
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TWD_I_DATA_RD = 2'h0,
    TWD_I_DATA_WR = 2'h1,
    TWD_I_ADDR_RD = 2'h2,
    TWD_I_ADDR_WR = 2'h3
  } twd_instr_t;
  typedef struct packed {
    twd_instr_t instr;  // Operation
    logic [7:0] data;   // Write byte
  } twd_req_t;
  typedef enum logic [1:0] {
    TWD_OP_READ  = 2'h0,
    TWD_OP_WRITE = 2'h1,
    TWD_OP_PAGE  = 2'h2,
    TWD_OP_ALL   = 2'h3
  } twd_fop_t;
  typedef struct packed {
    logic        valid;  // One-cycle strobe
    twd_fop_t    op;     // Flash operation
    logic [15:0] addr;   // Flash byte address
    logic [7:0]  wdata;  // Write byte
  } twd_flash_t;
endpackage : twd_pkg
`default_nettype wire

/* twd_sync3.sv */
`default_nettype none
// Three-stage synchroniser; output moves once stages two and three agree
module twd_sync3 (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic async_i,
  output logic      level_q
);
  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic s1_q;  // Metastable catch, read by s2 only
  logic s2_q;  // Second stage
  logic s3_q;  // Third stage

  // Shift chain
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Qualified level
  always_ff @(posedge clk) begin
    if (srst) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule : twd_sync3
`default_nettype wire

/* twd_access_port.sv */
`default_nettype none
module twd_access_port
  import twd_pkg::*;
#(
  parameter logic [7:0] IDENT_VALUE = 8'h5A,  // Arbitrary identity value
  parameter logic [7:0] REV_VALUE   = 8'h01   // Arbitrary revision value
) (
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  halted,            // Core halted, peripherals stalled
  input  wire logic  debug_clock_input, // Link clock from programmer
  input  wire logic  debug_data_i,      // Data line level
  output logic       debug_data_o,      // Data line drive value
  output logic       debug_data_oe_n,   // Low while device drives
  output logic       reset_request,     // User reset from shared pin
  input  wire logic  [7:0] port_i,      // Port pin levels
  output logic       [7:0] port_o,      // Port drive values
  output logic       [7:0] port_oe_n,   // Low while port bit driven
  output twd_flash_t flash_cmd,         // Flash operation strobe
  input  wire logic  [7:0] flash_rdata  // Flash read byte
);
  // ----------------------------------------------------------------
  // Link domain reset
  // ----------------------------------------------------------------
  logic link_rst;  // srst carried onto the link clock

  twd_sync3 u_lrst (
    .clk     (debug_clock_input),
    .srst    (1'b0),
    .async_i (srst),
    .level_q (link_rst)
  );

  // ----------------------------------------------------------------
  // Link domain framing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    L_IDLE, L_INSTR, L_WDATA, L_TURN, L_RDATA
  } twd_lstate_t;

  twd_lstate_t lst_q;           // Link framing state
  logic [3:0]  lcnt_q;          // Bit counter
  logic [7:0]  lsh_q;           // Shift register
  twd_instr_t  linstr_q;        // Captured instruction
  twd_req_t    lreq_q;          // Held request word
  logic        lreq_tog_q;      // Request toggle
  logic        lack_lvl;        // Acknowledge seen on link side
  logic        ldrv_q;          // Device owns the data line
  logic        ldo_q;           // Bit being driven
  logic        ack_tog_q;       // Core acknowledge toggle
  logic [7:0]  rd_data_q;       // Read byte held for the link

  twd_sync3 u_ack (
    .clk     (debug_clock_input),
    .srst    (link_rst),
    .async_i (ack_tog_q),
    .level_q (lack_lvl)
  );

  // Frame sequencer on the programmer's clock
  always_ff @(posedge debug_clock_input) begin
    if (link_rst) begin
      lst_q      <= L_IDLE;
      lcnt_q     <= 4'h0;
      lsh_q      <= 8'h00;
      linstr_q   <= TWD_I_DATA_RD;
      lreq_q     <= '0;
      lreq_tog_q <= 1'b0;
      ldrv_q     <= 1'b0;
      ldo_q      <= 1'b1;
    end else begin
      case (lst_q)
        // Start bit is a low level
        L_IDLE: begin
          ldrv_q <= 1'b0;
          lcnt_q <= 4'h0;
          if (!debug_data_i) begin
            lst_q <= L_INSTR;
          end
        end
        // Instruction, first bit is msb
        L_INSTR: begin
          linstr_q <= twd_instr_t'({linstr_q[0], debug_data_i});
          if (lcnt_q == TWD_INSTR_BITS - 4'h1) begin
            lcnt_q <= 4'h0;
            // Low instruction bit arrives now; set means a write frame
            if (debug_data_i) begin
              lst_q <= L_WDATA;
            end else begin
              // Reads post the request at once
              lreq_q     <= '{instr: twd_instr_t'({linstr_q[0], debug_data_i}),
                              data: 8'h00};
              lreq_tog_q <= ~lreq_tog_q;
              lst_q      <= L_TURN;
            end
          end else begin
            lcnt_q <= lcnt_q + 4'h1;
          end
        end
        // Write byte, msb first
        L_WDATA: begin
          lsh_q <= {lsh_q[6:0], debug_data_i};
          if (lcnt_q == TWD_DATA_BITS - 4'h1) begin
            lreq_q     <= '{instr: linstr_q, data: {lsh_q[6:0], debug_data_i}};
            lreq_tog_q <= ~lreq_tog_q;
            lst_q      <= L_IDLE;
          end else begin
            lcnt_q <= lcnt_q + 4'h1;
          end
        end
        // Turnaround, wait for the core answer
        L_TURN: begin
          if (lcnt_q < TWD_TURN_CYC - 4'h1) begin
            lcnt_q <= lcnt_q + 4'h1;
          end else if (lack_lvl == lreq_tog_q) begin
            lsh_q  <= {rd_data_q[6:0], 1'b0};
            ldo_q  <= rd_data_q[7];
            ldrv_q <= 1'b1;
            lcnt_q <= 4'h0;
            lst_q  <= L_RDATA;
          end
        end
        // Read byte out, msb first
        L_RDATA: begin
          if (lcnt_q == TWD_DATA_BITS - 4'h1) begin
            ldrv_q <= 1'b0;
            ldo_q  <= 1'b1;
            lst_q  <= L_IDLE;
          end else begin
            ldo_q  <= lsh_q[7];
            lsh_q  <= {lsh_q[6:0], 1'b0};
            lcnt_q <= lcnt_q + 4'h1;
          end
        end
        default: begin
          lst_q <= L_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core domain registers
  // ----------------------------------------------------------------
  logic       req_lvl;      // Synced request toggle
  logic       req_seen_q;   // Last request handled
  logic       req_ev;       // New request this cycle
  logic [7:0] target_q;     // Target select address
  logic [7:0] fpctrl_q;     // Flash programming control
  logic [7:0] latch_q;      // Port latch
  logic [7:0] inmode_q;     // Port input mode
  logic [7:0] outmode_q;    // Port output mode
  logic [7:0] pin_lvl;      // Synced port levels
  logic       rst_pin_lvl;  // Synced shared reset pin
  logic       is_wr;        // Data write event
  logic       is_rd;        // Data read event

  twd_sync3 u_req (
    .clk     (clk),
    .srst    (srst),
    .async_i (lreq_tog_q),
    .level_q (req_lvl)
  );

  for (genvar g = 0; g < 8; g++) begin : g_pin
    twd_sync3 u_pin (
      .clk     (clk),
      .srst    (srst),
      .async_i (port_i[g]),
      .level_q (pin_lvl[g])
    );
  end

  twd_sync3 u_rpin (
    .clk     (clk),
    .srst    (srst),
    .async_i (debug_clock_input),
    .level_q (rst_pin_lvl)
  );

  assign req_ev = req_lvl != req_seen_q;
  assign is_wr  = req_ev && (lreq_q.instr == TWD_I_DATA_WR);
  assign is_rd  = req_ev && (lreq_q.instr == TWD_I_DATA_RD);

  // Port latch read shows pins, shared bit reads the latch
  function automatic logic [7:0] port_view(input logic [7:0] pins,
                                           input logic [7:0] lat);
    port_view = {lat[TWD_SHARED_BIT], pins[6:0]};
  endfunction : port_view

  // ----------------------------------------------------------------
  // Flash command sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    F_CMD, F_ADDR_HI, F_ADDR_LO, F_LEN, F_DATA
  } twd_fstate_t;

  twd_fstate_t fst_q;     // Flash sequencer state
  twd_fop_t    fop_q;     // Pending operation
  logic [15:0] faddr_q;   // Flash address
  logic [7:0]  flen_q;    // Bytes left, zero means 256
  logic        fp_wr;     // Write to flash data
  logic        fp_rd;     // Read of flash data
  logic        fp_en;     // Programming enabled

  assign fp_wr = is_wr && (target_q == TWD_ADR_FPDATA);
  assign fp_rd = is_rd && (target_q == TWD_ADR_FPDATA);
  assign fp_en = fpctrl_q[TWD_FPC_ENABLE];

  // Command, address, length, data sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      fst_q     <= F_CMD;
      fop_q     <= TWD_OP_READ;
      faddr_q   <= 16'h0000;
      flen_q    <= 8'h00;
      flash_cmd <= '0;
    end else begin
      flash_cmd.valid <= 1'b0;
      case (fst_q)
        // Command decode
        F_CMD: begin
          if (fp_wr && fp_en) begin
            case (lreq_q.data)
              TWD_CMD_BREAD: begin
                fop_q <= TWD_OP_READ;
                fst_q <= F_ADDR_HI;
              end
              TWD_CMD_BWRITE: begin
                fop_q <= TWD_OP_WRITE;
                fst_q <= F_ADDR_HI;
              end
              TWD_CMD_PERASE: begin
                fop_q <= TWD_OP_PAGE;
                fst_q <= F_ADDR_HI;
              end
              TWD_CMD_DERASE: begin
                flash_cmd <= '{valid: 1'b1, op: TWD_OP_ALL,
                               addr: 16'h0000, wdata: 8'h00};
              end
              default: begin
                fst_q <= F_CMD;
              end
            endcase
          end
        end
        // Address high byte
        F_ADDR_HI: begin
          if (fp_wr) begin
            faddr_q[15:8] <= lreq_q.data;
            fst_q         <= F_ADDR_LO;
          end
        end
        // Address low byte, page erase fires here
        F_ADDR_LO: begin
          if (fp_wr) begin
            faddr_q[7:0] <= lreq_q.data;
            if (fop_q == TWD_OP_PAGE) begin
              flash_cmd <= '{valid: 1'b1, op: TWD_OP_PAGE,
                             addr: {faddr_q[15:8], lreq_q.data}, wdata: 8'h00};
              fst_q     <= F_CMD;
            end else begin
              fst_q <= F_LEN;
            end
          end
        end
        // Length byte, reads prefetch the first byte
        F_LEN: begin
          if (fp_wr) begin
            flen_q <= lreq_q.data;
            fst_q  <= F_DATA;
            if (fop_q == TWD_OP_READ) begin
              flash_cmd <= '{valid: 1'b1, op: TWD_OP_READ,
                             addr: faddr_q, wdata: 8'h00};
            end
          end
        end
        // Data bytes, one flash access each except the last read byte
        F_DATA: begin
          if ((fop_q == TWD_OP_WRITE && fp_wr) || (fop_q == TWD_OP_READ && fp_rd)) begin
            faddr_q <= faddr_q + 16'h0001;
            flen_q  <= flen_q - 8'h01;
            if (flen_q == 8'h01) begin
              fst_q <= F_CMD;
            end
            if (fop_q == TWD_OP_WRITE) begin
              flash_cmd <= '{valid: 1'b1, op: TWD_OP_WRITE,
                             addr: faddr_q, wdata: lreq_q.data};
            end else if (flen_q != 8'h01) begin
              flash_cmd <= '{valid: 1'b1, op: TWD_OP_READ,
                             addr: faddr_q + 16'h0001, wdata: 8'h00};
            end
          end
        end
        default: begin
          fst_q <= F_CMD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request handling and register file
  // ----------------------------------------------------------------
  // Address and data writes
  always_ff @(posedge clk) begin
    if (srst) begin
      target_q  <= TWD_RST_TARGET;
      fpctrl_q  <= TWD_RST_FPCTRL;
      latch_q   <= TWD_RST_LATCH;
      inmode_q  <= TWD_RST_MODE;
      outmode_q <= TWD_RST_OUTMODE;
    end else if (req_ev && lreq_q.instr == TWD_I_ADDR_WR) begin
      target_q <= lreq_q.data;
    end else if (is_wr) begin
      case (target_q)
        TWD_ADR_FPCTRL:  fpctrl_q  <= lreq_q.data;
        TWD_ADR_PLATCH:  latch_q   <= lreq_q.data;
        TWD_ADR_INMODE:  inmode_q  <= lreq_q.data;
        TWD_ADR_OUTMODE: outmode_q <= lreq_q.data;
        default: begin
          fpctrl_q <= fpctrl_q;
        end
      endcase
    end
  end

  // Read byte and acknowledge toggle
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_q  <= 8'h00;
      ack_tog_q  <= 1'b0;
      req_seen_q <= 1'b0;
    end else if (req_ev) begin
      req_seen_q <= req_lvl;
      ack_tog_q  <= req_lvl;
      if (lreq_q.instr == TWD_I_ADDR_RD) begin
        rd_data_q <= target_q;
      end else if (lreq_q.instr == TWD_I_DATA_RD) begin
        case (target_q)
          TWD_ADR_IDENT:   rd_data_q <= IDENT_VALUE;
          TWD_ADR_REV:     rd_data_q <= REV_VALUE;
          TWD_ADR_FPCTRL:  rd_data_q <= fpctrl_q;
          TWD_ADR_FPDATA:  rd_data_q <= flash_rdata;
          TWD_ADR_PLATCH:  rd_data_q <= port_view(pin_lvl, latch_q);
          TWD_ADR_INMODE:  rd_data_q <= inmode_q;
          TWD_ADR_OUTMODE: rd_data_q <= outmode_q;
          default:         rd_data_q <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin sharing
  // ----------------------------------------------------------------
  // Port drive: where input mode is set, push-pull bits drive, open-drain only pulls low; the shared bit is released while halted
  always_comb begin
    port_o    = latch_q;
    port_oe_n = ~((outmode_q | ~latch_q) & inmode_q);
    if (halted) begin
      port_o[TWD_SHARED_BIT]    = 1'b1;
      port_oe_n[TWD_SHARED_BIT] = 1'b1;
    end
  end

  assign debug_data_o    = ldo_q;
  assign debug_data_oe_n = ~ldrv_q;
  assign reset_request   = ~halted & ~rst_pin_lvl;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_addr_capture: assert property (
    req_ev && lreq_q.instr == TWD_I_ADDR_WR |=> target_q == $past(lreq_q.data))
    else $error("address write not captured");
  a_ident_read: assert property (
    is_rd && target_q == TWD_ADR_IDENT |=> rd_data_q == IDENT_VALUE)
    else $error("identity read wrong");
  a_rev_read: assert property (
    is_rd && target_q == TWD_ADR_REV |=> rd_data_q == REV_VALUE)
    else $error("revision read wrong");
  a_fpctrl_rw: assert property (
    is_rd && target_q == TWD_ADR_FPCTRL |=> rd_data_q == $past(fpctrl_q))
    else $error("control readback wrong");
  a_latch_drive: assert property (
    is_wr && target_q == TWD_ADR_PLATCH
    |=> port_o[6:0] == $past(lreq_q.data[6:0]))
    else $error("latch not on port");
  a_mode_keep: assert property (
    !(is_wr && target_q == TWD_ADR_INMODE) |=> inmode_q == $past(inmode_q))
    else $error("input mode changed unasked");
  a_outmode_rw: assert property (
    is_wr && target_q == TWD_ADR_OUTMODE |=> outmode_q == $past(lreq_q.data))
    else $error("output mode not written");
  a_erase_all: assert property (
    fst_q == F_CMD && fp_wr && fp_en && lreq_q.data == TWD_CMD_DERASE
    |=> flash_cmd.valid && flash_cmd.op == TWD_OP_ALL)
    else $error("device erase not issued");
  a_seq_order: assert property (
    fst_q == F_CMD && fp_wr && fp_en && lreq_q.data == TWD_CMD_BWRITE
    |=> fst_q == F_ADDR_HI)
    else $error("block write did not expect address");
  a_pin_lent: assert property (
    halted |-> port_oe_n[TWD_SHARED_BIT] && !reset_request)
    else $error("shared pins not released");
  a_ack_bound: assert property (
    req_ev |=> ack_tog_q == req_seen_q)
    else $error("acknowledge missing");

  c_page_erase: cover property (flash_cmd.valid && flash_cmd.op == TWD_OP_PAGE);
  c_block_rd:   cover property (fp_rd && fst_q == F_DATA);
  c_block_wr:   cover property (flash_cmd.valid && flash_cmd.op == TWD_OP_WRITE);
  c_ident:      cover property (is_rd && target_q == TWD_ADR_IDENT);
endmodule : twd_access_port
`default_nettype wire

/* twd_sync3_note_unused.sv */
`default_nettype none
`default_nettype wire

/* twd_prog_model.sv */
`default_nettype none
// ------------------------------
// Programmer model
// ------------------------------
module twd_prog_model
  import twd_pkg::*;
(
  output logic       ck,      // Link clock, idles high
  output logic       p_en,    // Programmer drives line
  output logic       p_bit,   // Programmer bit
  input  wire logic  dl,      // Resolved line
  input  wire logic  oe_n,    // Device drive enable
  output logic       rd_stb,  // Byte read done
  output logic [7:0] rd_byte  // Byte read
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ck = 1'b1;
    p_en = 1'b0;
    p_bit = 1'b1;
    rd_stb = 1'b0;
    rd_byte = 8'h00;
  end
  // Clock periods; data moves 1 ns after each rise
  task automatic tick(input int n);
    repeat (n) begin
      #61.5 ck = 1'b0;
      #62.5 ck = 1'b1;
      #1;
    end
  endtask : tick
  // Shared reset pin held low
  task automatic hold_low(input int n);
    ck = 1'b0;
    #(n * 125 - 1) ck = 1'b1;
    #1;
  endtask : hold_low
  // One bit, taken at the next rise
  task automatic put(input logic b);
    p_en = 1'b1;
    p_bit = b;
    tick(1);
  endtask : put
  // Start, instruction, byte out or
  task automatic frame(input twd_instr_t ins, input logic [7:0] wb);
    put(1'b0);
    put(ins[1]);
    put(ins[0]);
    p_en = ins[0];  // Reads release the line
    for (int i = 0; i < 40 && !ins[0] && oe_n; i++) tick(1);
    for (int i = 7; i >= 0; i--) begin
      if (ins[0]) put(wb[i]);
      else begin
        #61.5 ck = 1'b0;
        rd_byte[i] = dl;
        #62.5 ck = 1'b1;
        #1;
      end
    end
    p_en = 1'b0;
    if (!ins[0]) rd_stb = 1'b1;
    tick(4);  // Idle gap so the core takes each request
    rd_stb = 1'b0;
  endtask : frame
endmodule : twd_prog_model
`default_nettype wire

/* two_wire_debug_prog_access_bench.sv */
`default_nettype none
// ------------------------------
// Bench for the access port
// ------------------------------
module two_wire_debug_prog_access_bench;
  import twd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, srst, halted, ck, p_en, p_bit, dl, dev_o, dev_oe_n, rst_req, rd_stb;
  logic  [7:0] port_i, port_o, port_oe_n, frd, rd_byte, v[4];
  logic [15:0] seed = 16'h36EC;  // Seed 14060
  twd_flash_t  fc;               // Flash strobe
  logic [26:0] expq[$];          // Expected results, oldest first
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  logic  [7:0] ra[6] = '{TWD_ADR_IDENT, TWD_ADR_REV, TWD_ADR_FPCTRL, TWD_ADR_INMODE,
                         TWD_ADR_OUTMODE, 8'h55};
  logic  [7:0] rv[6] = '{8'h5A, 8'h01, TWD_RST_FPCTRL, TWD_RST_MODE, TWD_RST_OUTMODE, 8'h00};
  logic  [7:0] wa[4] = '{TWD_ADR_FPCTRL, TWD_ADR_INMODE, TWD_ADR_OUTMODE, TWD_ADR_PLATCH};
  // Line level: device, programmer, else pull-up
  assign dl = !dev_oe_n ? dev_o : (p_en ? p_bit : 1'b1);
  twd_access_port #(.IDENT_VALUE(8'h5A), .REV_VALUE(8'h01)) DUT (.clk(clk), .srst(srst),
    .halted(halted), .debug_clock_input(ck),
    .debug_data_i(dl), .debug_data_o(dev_o), .debug_data_oe_n(dev_oe_n),
    .reset_request(rst_req), .port_i(port_i), .port_o(port_o), .port_oe_n(port_oe_n),
    .flash_cmd(fc), .flash_rdata(frd));
  twd_prog_model prog (.ck(ck), .p_en(p_en), .p_bit(p_bit), .dl(dl), .oe_n(dev_oe_n),
    .rd_stb(rd_stb), .rd_byte(rd_byte));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [26:0] fl(input twd_fop_t op, input logic [15:0] a,
                                     input logic [7:0] w);
    return {1'b1, op, a, w};
  endfunction : fl
  // Port drive enables from mode and latch bytes
  function automatic logic [7:0] oen(input logic [7:0] im, om, lt, input logic h);
    logic [7:0] r;
    r = ~(im & (om | ~lt));
    r[7] = r[7] | h;
    return r;
  endfunction : oen
  function automatic logic [26:0] pop();
    if (expq.size() == 0) return '1;
    return expq.pop_front();
  endfunction : pop
  task automatic chk(input string nm, input logic [26:0] e, input logic [26:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    prog.frame(TWD_I_ADDR_WR, a);
    prog.frame(TWD_I_DATA_WR, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    prog.frame(TWD_I_ADDR_WR, a);
    expq.push_back({19'h0, e});
    prog.frame(TWD_I_DATA_RD, 8'h00);
  endtask : rd
  task automatic fd(input logic [7:0] d);
    prog.frame(TWD_I_DATA_WR, d);
  endtask : fd
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // Each result takes the oldest note
  always @(posedge rd_stb) chk("read byte", pop(), {19'h0, rd_byte});
  always @(posedge clk) begin
    if (fc.valid === 1'b1)
      chk("flash strobe", pop(), fl(fc.op, fc.op == TWD_OP_ALL ? 16'h0 : fc.addr,
          fc.op == TWD_OP_WRITE ? fc.wdata : 8'h0));
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    srst = 1'b1;
    halted = 1'b1;  // Traffic only while halted
    port_i = 8'h00;
    frd = 8'h00;
    repeat (4) @(posedge clk);
    prog.tick(6);
    @(posedge clk) srst <= 1'b0;
    prog.tick(5);
    chk("port drive", {19'h0, 8'hFF}, {19'h0, port_oe_n});  // Shared bit released
    wr(TWD_ADR_IDENT, 8'hC3);  // Read-only write
    foreach (ra[i]) rd(ra[i], rv[i]);  // Reset table
    expq.push_back({19'h0, 8'h55});
    prog.frame(TWD_I_ADDR_RD, 8'h00);  // Address readback
    seed = lfsr(seed);
    @(posedge clk) port_i <= seed[7:0];
    rd(TWD_ADR_PLATCH, {1'b1, seed[6:0]});  // Pin levels
    $display("test reset values done");
    foreach (wa[i]) begin
      seed = lfsr(seed);
      v[i] = seed[15:8];
      wr(wa[i], v[i]);  // Random writes
    end
    for (int i = 0; i < 3; i++) rd(wa[i], v[i]);  // Readback
    rd(TWD_ADR_PLATCH, {v[3][7], port_i[6:0]});  // Latch readback
    chk("port out", {19'h0, 1'b1, v[3][6:0]}, {19'h0, port_o});  // Halted
    chk("port drive", {19'h0, oen(v[1], v[2], v[3], 1'b1)}, {19'h0, port_oe_n});  // Modes
    $display("test register access done");
    wr(TWD_ADR_FPCTRL, 8'h00);  // Programming disabled
    wr(TWD_ADR_FPDATA, TWD_CMD_DERASE);  // Disabled, no strobe
    wr(TWD_ADR_FPCTRL, 8'h01);  // Programming enabled
    wr(TWD_ADR_FPDATA, 8'h09);  // Unknown code ignored
    expq.push_back(fl(TWD_OP_ALL, 16'h0, 8'h0));
    fd(TWD_CMD_DERASE);  // Whole erase
    seed = lfsr(seed);
    fd(TWD_CMD_PERASE);  // Page erase
    fd(seed[15:8]);  // Address high
    expq.push_back(fl(TWD_OP_PAGE, seed, 8'h0));
    fd(seed[7:0]);  // Address low
    fd(TWD_CMD_BWRITE);  // Block write
    fd(seed[15:8]);  // Address high
    fd(seed[7:0]);  // Address low
    fd(8'h02);  // Length
    for (int i = 0; i < 2; i++) begin
      expq.push_back(fl(TWD_OP_WRITE, seed + 16'(i), v[i]));
      fd(v[i]);  // Data bytes
    end
    @(posedge clk) frd <= v[2];
    fd(TWD_CMD_BREAD);  // Block read
    fd(seed[15:8]);  // Address high
    fd(seed[7:0]);  // Address low
    expq.push_back(fl(TWD_OP_READ, seed, 8'h0));
    fd(8'h01);  // Length
    rd(TWD_ADR_FPDATA, v[2]);  // Flash byte returned
    $display("test flash commands done");
    fork
      prog.hold_low(4);
      #300 chk("reset request", 27'h0, {26'h0, rst_req});  // Halted, pin lent
    join
    @(posedge clk) halted <= 1'b0;
    repeat (2) @(posedge clk);
    chk("port out", {19'h0, v[3]}, {19'h0, port_o});  // Pin back to user
    chk("port drive", {19'h0, oen(v[1], v[2], v[3], 1'b0)}, {19'h0, port_oe_n});  // Run
    fork
      prog.hold_low(4);
      #300 chk("reset request", 27'h1, {26'h0, rst_req});  // Run mode reset
    join
    $display("test run mode done");
    repeat (10) @(posedge clk);
    chk("notes left", 27'h0, 27'(expq.size()));  // Every result seen
    finish_test();
  end
endmodule : two_wire_debug_prog_access_bench
`default_nettype wire
